// ### core/lpt_pkg.sv
// Purpose: Shared constants for the LCD panel timing generator.
// Assumes: 32-bit Avalon-MM register words at byte offsets.
// Notes:   Register table entries are indexed 0 to 8 in the order below.
package lpt_pkg;
   localparam int REG_N = 9;
   localparam int CW    = 10;
   localparam int PW    = 12;

   localparam logic [7:0] OFS_HTOTAL = 8'h20;
   localparam logic [7:0] OFS_HDISP  = 8'h24;
   localparam logic [7:0] OFS_HSTART = 8'h28;
   localparam logic [7:0] OFS_LSYNC  = 8'h2c;
   localparam logic [7:0] OFS_VTOTAL = 8'h30;
   localparam logic [7:0] OFS_VDISP  = 8'h34;
   localparam logic [7:0] OFS_VSTART = 8'h38;
   localparam logic [7:0] OFS_FSYNC  = 8'h3c;
   localparam logic [7:0] OFS_CTRL   = 8'h80;
   localparam logic [7:0] OFS_STAT   = 8'h84;

   localparam int I_HTOTAL = 0;
   localparam int I_HDISP  = 1;
   localparam int I_HSTART = 2;
   localparam int I_LSYNC  = 3;
   localparam int I_VTOTAL = 4;
   localparam int I_VDISP  = 5;
   localparam int I_VSTART = 6;
   localparam int I_FSYNC  = 7;
   localparam int I_CTRL   = 8;

   localparam logic [REG_N-1:0][7:0] REG_OFS = {OFS_CTRL, OFS_FSYNC, OFS_VSTART,
      OFS_VDISP, OFS_VTOTAL, OFS_LSYNC, OFS_HSTART, OFS_HDISP, OFS_HTOTAL};
   localparam logic [REG_N-1:0][31:0] REG_MASK = {32'h000000f3, 32'h008703ff,
      32'h000003ff, 32'h000003ff, 32'h000003ff, 32'h00ff03ff, 32'h000003ff,
      32'h0000007f, 32'h0000007f};
   localparam logic [REG_N-1:0][31:0] REG_RST = {REG_N{32'h00000000}};

   localparam int UNIT_SHIFT     = 3;
   localparam int SYNC_POL_BIT   = 23;
   localparam int SYNC_W_LSB     = 16;
   localparam int LSYNC_W_BITS   = 7;
   localparam int FSYNC_W_BITS   = 3;
   localparam int CTRL_TFT_BIT   = 0;
   localparam int CTRL_EN_BIT    = 1;
   localparam int CTRL_DIV_LSB   = 4;
   localparam int DIV_W          = 4;
   localparam int STAT_LINE_LSB  = 16;
   localparam logic [PW-1:0] PASSIVE_HSTART = 12'h016;
   localparam logic [PW-1:0] TFT_HSTART_ADD = 12'h005;
   localparam logic [PW-1:0] LSYNC_ADD      = 12'h001;
   localparam logic [PW-1:0] ONE_POS        = 12'h001;

   typedef enum logic [0:0] {
      LPT_BUS_IDLE   = 1'b0,
      LPT_BUS_ANSWER = 1'b1
   } lpt_bus_e;
endpackage

// ### core/lpt_axis_counter.sv
// Purpose: One timing axis: a wrapping position counter with a window and a pulse.
// Assumes: Positions are zero based; lengths are at least one.
// Notes:   Window and pulse are combinational from the counter.
`timescale 1ns/1ps
module lpt_axis_counter (
   input  wire logic                   core_clk_in,
   input  wire logic                   rst_n_in,
   input  wire logic                   step_in,
   input  wire logic                   clear_in,
   input  wire logic [lpt_pkg::CW-1:0] last_in,
   input  wire logic [lpt_pkg::PW-1:0] win_begin_in,
   input  wire logic [lpt_pkg::PW-1:0] win_len_in,
   input  wire logic [lpt_pkg::PW-1:0] pulse_begin_in,
   input  wire logic [lpt_pkg::PW-1:0] pulse_len_in,
   output logic      [lpt_pkg::CW-1:0] count_out,
   output logic                        wrap_out,
   output logic                        window_out,
   output logic                        pulse_out
);
   logic [lpt_pkg::CW-1:0] count;
   logic [lpt_pkg::CW-1:0] next_count;
   logic [lpt_pkg::PW:0]   pos;
   logic [lpt_pkg::PW:0]   win_end;
   logic [lpt_pkg::PW:0]   pulse_end;

   always_comb begin
      // Wrapping also on a count beyond the total keeps a shrunk total safe.
      wrap_out   = step_in && (count >= last_in); // see R20
      next_count = count;
      if (clear_in) begin
         next_count = '0;
      end else if (wrap_out) begin
         next_count = '0;
      end else if (step_in) begin
         next_count = count + 1'b1;
      end
      pos        = {3'b000, count};
      win_end    = {1'b0, win_begin_in} + {1'b0, win_len_in};
      pulse_end  = {1'b0, pulse_begin_in} + {1'b0, pulse_len_in};
      window_out = (pos >= {1'b0, win_begin_in}) && (pos < win_end);
      pulse_out  = (pos >= {1'b0, pulse_begin_in}) && (pos < pulse_end);
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign count_out = count;
endmodule // lpt_axis_counter

// ### core/lpt_timing_gen.sv
// Purpose: Programmable LCD panel timing generator with an Avalon-MM register slave.
// Assumes: Byte addresses, whole 32-bit register words.
// Notes:   Pixel rate is the core clock divided by the control divider plus one.
//
// What this block does
// R1: Horizontal display period field counts 8-pixel units, stored as count/8 minus one.
// R2: Passive panels: software uses display period at least 32, in 16-pixel steps.
// R3: TFT panels: software uses display period at least 8, in 8-pixel steps.
// R4: Passive panels: start field is zero and display starts at pixel 22.
// R5: TFT panels: display starts at the start field plus 5 pixels.
// R6: Software keeps start plus period below total, blanking at least 8 clocks.
// R7: Line sync polarity bit 23: zero gives active low, one active high.
// R8: Passive panels: software sets line sync polarity to active high.
// R9: Line sync pulse lasts the width field at bits 22-16 plus one pixels.
// R10: Line sync pulse starts at the start field plus one pixel.
// R11: Passive panels: software keeps line sync width plus start below total.
// R12: Vertical total field holds lines minus one, at most 1024 lines.
// R13: Vertical display field holds displayed lines minus one.
// R14: TFT display starts at the field line; passive panels write zero there.
// R15: Software keeps vertical start plus period strictly below vertical total.
// R16: Horizontal total field counts 8-pixel units, stored as count/8 minus one.
// R17: Frame sync polarity bit 23: zero gives active low, one active high.
// R18: Frame sync pulse lasts the width field at bits 18-16 plus one lines.
// R19: Frame sync pulse starts at the start field line.
// R20: Pixel counter wraps at total, line counter steps per wrap; active inside both.
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
module lpt_timing_gen (
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [7:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [3:0]  avs_byteenable_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   output logic             line_sync_pin_out,
   output logic             frame_sync_pin_out,
   output logic             display_active_out,
   output logic             frame_start_out
);
   logic [lpt_pkg::REG_N-1:0][31:0] word;
   logic [lpt_pkg::REG_N-1:0][31:0] next_word;
   logic [lpt_pkg::REG_N-1:0]       hit;
   logic                            stat_hit;
   logic [31:0]                     lane_mask;
   lpt_pkg::lpt_bus_e               bus_state;
   lpt_pkg::lpt_bus_e               next_bus_state;
   logic                            waitreq;
   logic                            next_waitreq;
   logic [31:0]                     rdata;
   logic [31:0]                     next_rdata;
   logic                            req;
   logic                            commit_wr;

   logic [6:0]              ht_field;
   logic [6:0]              hdp_field;
   logic [9:0]              hds_field;
   logic                    lsync_pol;
   logic [6:0]              lsync_w;
   logic [9:0]              lsync_s;
   logic [9:0]              vt_field;
   logic [9:0]              vdp_field;
   logic [9:0]              vds_field;
   logic                    fsync_pol;
   logic [2:0]              fsync_w;
   logic [9:0]              fsync_s;
   logic                    panel_tft;
   logic                    run_en;
   logic [lpt_pkg::DIV_W-1:0] div_field;

   logic [lpt_pkg::CW-1:0]  h_last;
   logic [lpt_pkg::PW-1:0]  h_begin;
   logic [lpt_pkg::PW-1:0]  h_len;
   logic [lpt_pkg::PW-1:0]  hs_begin;
   logic [lpt_pkg::PW-1:0]  hs_len;
   logic [lpt_pkg::PW-1:0]  v_begin;
   logic [lpt_pkg::PW-1:0]  v_len;
   logic [lpt_pkg::PW-1:0]  vs_begin;
   logic [lpt_pkg::PW-1:0]  vs_len;

   logic [lpt_pkg::DIV_W-1:0] div_cnt;
   logic [lpt_pkg::DIV_W-1:0] next_div_cnt;
   logic                    pix_en;
   logic                    line_en;
   logic [lpt_pkg::CW-1:0]  h_count;
   logic [lpt_pkg::CW-1:0]  v_count;
   logic                    h_wrap;
   logic                    v_wrap;
   logic                    h_win;
   logic                    v_win;
   logic                    h_pulse;
   logic                    v_pulse;

   logic                    line_sync;
   logic                    frame_sync;
   logic                    disp_act;
   logic                    frm_start;
   logic                    next_line_sync;
   logic                    next_frame_sync;
   logic                    next_disp_act;
   logic                    next_frm_start;

   // Avalon-MM slave: one wait cycle, then the access completes.
   assign req       = avs_read_in || avs_write_in;
   assign commit_wr = avs_write_in && (bus_state == lpt_pkg::LPT_BUS_ANSWER);

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign lane_mask[gi*8 +: 8] = {8{avs_byteenable_in[gi]}};
      end
      for (gi = 0; gi < lpt_pkg::REG_N; gi++) begin : g_reg
         assign hit[gi] = (avs_address_in == lpt_pkg::REG_OFS[gi]);
         always_comb begin
            next_word[gi] = word[gi];
            if (commit_wr && hit[gi]) begin
               next_word[gi] = ((word[gi] & ~lane_mask) |
                                (avs_writedata_in & lane_mask)) &
                               lpt_pkg::REG_MASK[gi];
            end
         end
      end
   endgenerate

   assign stat_hit = (avs_address_in == lpt_pkg::OFS_STAT);

   always_comb begin
      next_bus_state = bus_state;
      next_rdata     = rdata;
      case (bus_state)
         lpt_pkg::LPT_BUS_IDLE: begin
            if (req) begin
               next_bus_state = lpt_pkg::LPT_BUS_ANSWER;
               // Unmapped addresses read as zero; writes to them are dropped.
               next_rdata = 32'h00000000;
               if (avs_read_in) begin
                  for (int i = 0; i < lpt_pkg::REG_N; i++) begin
                     if (hit[i]) begin
                        next_rdata = word[i];
                     end
                  end
                  if (stat_hit) begin
                     // Stopped timing reports its syncs inactive, as the pins show.
                     next_rdata = {disp_act, run_en && h_pulse, run_en && v_pulse, 3'b000,
                                   v_count, 6'h00, h_count};
                  end
               end
            end
         end
         lpt_pkg::LPT_BUS_ANSWER: begin
            next_bus_state = lpt_pkg::LPT_BUS_IDLE;
         end
         default: begin
            next_bus_state = lpt_pkg::LPT_BUS_IDLE;
         end
      endcase
      next_waitreq = (next_bus_state != lpt_pkg::LPT_BUS_ANSWER);
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus_state <= lpt_pkg::LPT_BUS_IDLE;
         waitreq   <= 1'b1;
         rdata     <= 32'h00000000;
         word      <= lpt_pkg::REG_RST;
      end else begin
         bus_state <= next_bus_state;
         waitreq   <= next_waitreq;
         rdata     <= next_rdata;
         word      <= next_word;
      end
   end

   // Field extraction.
   assign ht_field  = word[lpt_pkg::I_HTOTAL][6:0];
   assign hdp_field = word[lpt_pkg::I_HDISP][6:0];
   assign hds_field = word[lpt_pkg::I_HSTART][9:0];
   assign lsync_pol = word[lpt_pkg::I_LSYNC][lpt_pkg::SYNC_POL_BIT];
   assign lsync_w   = word[lpt_pkg::I_LSYNC][lpt_pkg::SYNC_W_LSB +: lpt_pkg::LSYNC_W_BITS];
   assign lsync_s   = word[lpt_pkg::I_LSYNC][9:0];
   assign vt_field  = word[lpt_pkg::I_VTOTAL][9:0];
   assign vdp_field = word[lpt_pkg::I_VDISP][9:0];
   assign vds_field = word[lpt_pkg::I_VSTART][9:0];
   assign fsync_pol = word[lpt_pkg::I_FSYNC][lpt_pkg::SYNC_POL_BIT];
   assign fsync_w   = word[lpt_pkg::I_FSYNC][lpt_pkg::SYNC_W_LSB +: lpt_pkg::FSYNC_W_BITS];
   assign fsync_s   = word[lpt_pkg::I_FSYNC][9:0];
   assign panel_tft = word[lpt_pkg::I_CTRL][lpt_pkg::CTRL_TFT_BIT];
   assign run_en    = word[lpt_pkg::I_CTRL][lpt_pkg::CTRL_EN_BIT];
   assign div_field = word[lpt_pkg::I_CTRL][lpt_pkg::CTRL_DIV_LSB +: lpt_pkg::DIV_W];

   // Derived positions, all zero based in pixels or lines.
   always_comb begin
      // Total of (field+1)*8 pixels, so the last pixel is field*8+7.
      h_last = {ht_field, 3'b111}; // see R16
      // Display length of (field+1)*8 pixels.
      h_len = {2'b00, hdp_field, 3'b000} +
              (lpt_pkg::ONE_POS << lpt_pkg::UNIT_SHIFT); // see R1
      if (panel_tft) begin
         h_begin = {2'b00, hds_field} + lpt_pkg::TFT_HSTART_ADD; // see R5
      end else begin
         // The start field is ignored on passive panels.
         h_begin = lpt_pkg::PASSIVE_HSTART; // see R4
      end
      hs_begin = {2'b00, lsync_s} + lpt_pkg::LSYNC_ADD; // see R10
      hs_len   = {5'b00000, lsync_w} + lpt_pkg::ONE_POS; // see R9
      v_begin  = {2'b00, vds_field}; // see R14
      v_len    = {2'b00, vdp_field} + lpt_pkg::ONE_POS; // see R13
      vs_begin = {2'b00, fsync_s}; // see R19
      vs_len   = {9'h000, fsync_w} + lpt_pkg::ONE_POS; // see R18
   end

   // Pixel-rate enable from the core clock.
   always_comb begin
      pix_en       = run_en && (div_cnt >= div_field);
      next_div_cnt = div_cnt + 1'b1;
      if (!run_en || pix_en) begin
         next_div_cnt = '0;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= next_div_cnt;
      end
   end

   // Horizontal and vertical axes.
   assign line_en = h_wrap; // see R20

   lpt_axis_counter u_horiz (
      .core_clk_in    (core_clk_in),
      .rst_n_in       (rst_n_in),
      .step_in        (pix_en),
      .clear_in       (!run_en),
      .last_in        (h_last),
      .win_begin_in   (h_begin),
      .win_len_in     (h_len),
      .pulse_begin_in (hs_begin),
      .pulse_len_in   (hs_len),
      .count_out      (h_count),
      .wrap_out       (h_wrap),
      .window_out     (h_win),
      .pulse_out      (h_pulse)
   );

   lpt_axis_counter u_vert (
      .core_clk_in    (core_clk_in),
      .rst_n_in       (rst_n_in),
      .step_in        (line_en),
      .clear_in       (!run_en),
      .last_in        (vt_field), // see R12
      .win_begin_in   (v_begin),
      .win_len_in     (v_len),
      .pulse_begin_in (vs_begin),
      .pulse_len_in   (vs_len),
      .count_out      (v_count),
      .wrap_out       (v_wrap),
      .window_out     (v_win),
      .pulse_out      (v_pulse)
   );

   // Registered panel outputs. Stopped timing holds syncs inactive.
   always_comb begin
      next_line_sync  = !lsync_pol ^ (run_en && h_pulse); // see R7
      next_frame_sync = !fsync_pol ^ (run_en && v_pulse); // see R17
      next_disp_act   = run_en && h_win && v_win; // see R20
      next_frm_start  = v_wrap;
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         line_sync  <= 1'b1;
         frame_sync <= 1'b1;
         disp_act   <= 1'b0;
         frm_start  <= 1'b0;
      end else begin
         line_sync  <= next_line_sync;
         frame_sync <= next_frame_sync;
         disp_act   <= next_disp_act;
         frm_start  <= next_frm_start;
      end
   end

   assign avs_readdata_out    = rdata;
   assign avs_waitrequest_out = waitreq;
   assign line_sync_pin_out   = line_sync;
   assign frame_sync_pin_out  = frame_sync;
   assign display_active_out  = disp_act;
   assign frame_start_out     = frm_start;
endmodule // lpt_timing_gen

// ### test/lpt_timing_gen_sva.sv
// Purpose: Port checker for the LCD panel timing generator.
// Assumes: Whole-word writes, so the shadows mirror the registers.
// Notes:   Lengths are counted in core clock cycles.
`timescale 1ns/1ps
module lpt_timing_gen_sva (
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [7:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [3:0]  avs_byteenable_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [31:0] avs_readdata_out,
   input  wire logic        avs_waitrequest_out,
   input  wire logic        line_sync_pin_out,
   input  wire logic        frame_sync_pin_out,
   input  wire logic        display_active_out,
   input  wire logic        frame_start_out
);
   logic [lpt_pkg::REG_N-1:0][31:0] sh, next_sh;
   logic [19:0] hs_n, vs_n, da_n, hs_gap, fs_gap, unit, line_len;
   logic [19:0] next_hs_n, next_vs_n, next_da_n, next_hs_gap, next_fs_gap;
   logic        vs_ok, hs_seen, fs_seen, next_vs_ok, next_hs_seen, next_fs_seen;
   logic        en, hs_act, vs_act, hs_rise, done;
   logic [31:0] ctl, lsy, fsy;
   always_comb begin
      next_sh = sh;
      for (int i = 0; i < lpt_pkg::REG_N; i++) begin
         if (avs_write_in && done && avs_address_in == lpt_pkg::REG_OFS[i]) begin
            next_sh[i] = avs_writedata_in & lpt_pkg::REG_MASK[i];
         end
      end
   end
   // First line sync and frame start after enabling only mark a period start; the first frame sync width is not measured.
   always_comb begin
      done         = !avs_waitrequest_out;
      ctl          = sh[lpt_pkg::I_CTRL];
      lsy          = sh[lpt_pkg::I_LSYNC];
      fsy          = sh[lpt_pkg::I_FSYNC];
      en           = ctl[lpt_pkg::CTRL_EN_BIT];
      hs_act       = line_sync_pin_out == lsy[23];
      vs_act       = frame_sync_pin_out == fsy[23];
      hs_rise      = en && hs_act && hs_n == 20'h0;
      unit         = 20'(ctl[7:4]) + 20'h1;
      line_len     = (20'(sh[lpt_pkg::I_HTOTAL][6:0]) + 20'h1) * 20'h8 * unit;
      next_hs_n    = (en && hs_act) ? hs_n + 20'h1 : 20'h0;
      next_vs_n    = (en && vs_act) ? vs_n + 20'h1 : 20'h0;
      next_da_n    = (en && display_active_out) ? da_n + 20'h1 : 20'h0;
      next_hs_gap  = hs_rise ? 20'h1 : hs_gap + 20'h1;
      next_fs_gap  = frame_start_out ? 20'h1 : fs_gap + 20'h1;
      next_hs_seen = en && (hs_seen || hs_rise);
      next_fs_seen = en && (fs_seen || frame_start_out);
      next_vs_ok   = en && (vs_ok || (!vs_act && vs_n != 20'h0));
   end
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sh <= lpt_pkg::REG_RST;
         {hs_n, vs_n, da_n, hs_gap, fs_gap, vs_ok, hs_seen, fs_seen} <= '0;
      end else begin
         sh <= next_sh;
         {hs_n, vs_n, da_n, hs_gap, fs_gap, vs_ok, hs_seen, fs_seen} <= {next_hs_n,
            next_vs_n, next_da_n, next_hs_gap, next_fs_gap, next_vs_ok, next_hs_seen, next_fs_seen};
      end
   end
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   chk_wait_answer:
      assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> done)
      else $error("waitrequest did not answer");
   chk_wait_single:
      assert property (done |=> !done) else $error("waitrequest low too long");
   chk_unmapped_zero:
      assert property (avs_read_in && done && !(avs_address_in inside {[8'h20:8'h3f], 8'h80,
         8'h84}) |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
   chk_lsync_readback:
      assert property (avs_read_in && done && avs_address_in == lpt_pkg::OFS_LSYNC
         |-> avs_readdata_out == lsy) else $error("line sync readback wrong");
   chk_line_width:
      assert property (en && !hs_act && hs_n != 20'h0 |-> hs_n == (20'(lsy[22:16]) + 20'h1) * unit)
      else $error("line sync width wrong");
   chk_line_period:
      assert property (hs_rise && hs_seen |-> hs_gap == line_len) else $error("line period wrong");
   chk_disp_width:
      assert property (en && !display_active_out && da_n != 20'h0
         |-> da_n == (20'(sh[lpt_pkg::I_HDISP][6:0]) + 20'h1) * 20'h8 * unit)
      else $error("display window width wrong");
   chk_frame_width:
      assert property (en && vs_ok && !vs_act && vs_n != 20'h0
         |-> vs_n == (20'(fsy[18:16]) + 20'h1) * line_len) else $error("frame sync width wrong");
   chk_frame_period:
      assert property (en && frame_start_out && fs_seen
         |-> fs_gap == (20'(sh[lpt_pkg::I_VTOTAL][9:0]) + 20'h1) * line_len)
      else $error("frame period wrong");
   chk_quiet_idle:
      assert property ((!en) [*3] |-> !display_active_out && !frame_start_out)
      else $error("outputs active while stopped");
   chk_sync_idle:
      assert property ((!en && $stable(sh)) [*3] |-> line_sync_pin_out == !lsy[23]
         && frame_sync_pin_out == !fsy[23]) else $error("idle sync level wrong");
   cov_frame: cover property (en && frame_start_out && fs_seen);
   cov_vsync: cover property (en && vs_ok && !vs_act && vs_n != 20'h0);
   cov_unmapped: cover property (avs_read_in && done && avs_address_in == 8'h40);
endmodule // lpt_timing_gen_sva
bind lpt_timing_gen lpt_timing_gen_sva u_sva (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_byteenable_in(avs_byteenable_in), .avs_writedata_in(avs_writedata_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .line_sync_pin_out(line_sync_pin_out), .frame_sync_pin_out(frame_sync_pin_out),
   .display_active_out(display_active_out), .frame_start_out(frame_start_out));

// ### test/lpt_panel_model.sv
// Purpose: Panel model that measures where the display window lands against the syncs.
// Assumes: The bench tells the panel which sync polarity it was set up for.
// Notes:   Reports cycles from line sync to first pixel and lines from frame sync to it.
`timescale 1ns/1ps
module lpt_panel_model (
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        line_sync_pin_in,
   input  wire logic        frame_sync_pin_in,
   input  wire logic        display_active_in,
   input  wire logic        line_pol_in,
   input  wire logic        frame_pol_in,
   output logic      [15:0] sync_to_pixels_out,
   output logic      [15:0] lines_to_pixels_out
);
   logic        hs_q, vs_q, da_q, armed;
   logic [15:0] cyc, ln;
   wire         hs = line_sync_pin_in == line_pol_in;
   wire         vs = frame_sync_pin_in == frame_pol_in;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         {hs_q, vs_q, da_q, armed, cyc, ln, sync_to_pixels_out, lines_to_pixels_out} <= '0;
      end else begin
         hs_q <= hs;
         vs_q <= vs;
         da_q <= display_active_in;
         cyc <= (hs && !hs_q) ? 16'h1 : cyc + 16'h1;
         if (vs && !vs_q) begin
            ln <= 16'h0;
            armed <= 1'b1;
         end else if (hs && !hs_q) begin
            ln <= ln + 16'h1;
         end
         // Only the first displayed line after a frame sync gives the line offset.
         if (display_active_in && !da_q) begin
            sync_to_pixels_out <= cyc;
            if (armed) begin
               lines_to_pixels_out <= ln;
            end
            armed <= 1'b0;
         end
      end
   end
endmodule // lpt_panel_model

// ### test/lpt_timing_gen_bench.sv
// Purpose: Self-checking bench for the LCD panel timing generator.
// Assumes: Whole-word register writes over Avalon-MM.
// Notes:   Timing is set while stopped, then run for just over two frames.
`timescale 1ns/1ps
module lpt_timing_gen_bench;
   logic        core_clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [7:0]  avs_address_in = 8'h00;
   logic        avs_read_in = 1'b0;
   logic        avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h00000000;
   logic [31:0] avs_readdata_out, rd;
   logic        avs_waitrequest_out, line_sync_pin_out, frame_sync_pin_out;
   logic        display_active_out, frame_start_out;
   logic        line_pol = 1'b0;
   logic        frame_pol = 1'b0;
   logic [15:0] sync_to_pixels, lines_to_pixels;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   always #2 core_clk_in = ~core_clk_in;
   lpt_timing_gen u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_byteenable_in(4'hf), .avs_writedata_in(avs_writedata_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .line_sync_pin_out(line_sync_pin_out), .frame_sync_pin_out(frame_sync_pin_out),
      .display_active_out(display_active_out), .frame_start_out(frame_start_out));
   lpt_panel_model u_panel (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .line_sync_pin_in(line_sync_pin_out), .frame_sync_pin_in(frame_sync_pin_out),
      .display_active_in(display_active_out), .line_pol_in(line_pol), .frame_pol_in(frame_pol),
      .sync_to_pixels_out(sync_to_pixels), .lines_to_pixels_out(lines_to_pixels));
   task automatic tally_and_finish();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Holds the request until waitrequest is sampled low, then releases it.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
      @(posedge core_clk_in);
      avs_address_in <= a;
      avs_writedata_in <= wd;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      do begin
         @(posedge core_clk_in);
      end while (avs_waitrequest_out !== 1'b0);
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask
   task automatic run_timing(input logic [7:0][31:0] v, input logic [31:0] ctrl, input int t);
      bus(1'b1, lpt_pkg::OFS_CTRL, 32'h00000000, rd);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, lpt_pkg::REG_OFS[i], v[i], rd);
      end
      bus(1'b1, lpt_pkg::OFS_CTRL, ctrl, rd);
      repeat (t) @(posedge core_clk_in);
   endtask
   task automatic test_reset_values();
      for (int i = 0; i < lpt_pkg::REG_N; i++) begin
         bus(1'b0, lpt_pkg::REG_OFS[i], 32'h0, rd);
         check("reset value", rd, lpt_pkg::REG_RST[i]);
      end
      bus(1'b0, lpt_pkg::OFS_STAT, 32'h0, rd);
      check("idle status", rd, 32'h00000000);
      bus(1'b1, 8'h40, 32'hffffffff, rd);
      bus(1'b0, 8'h40, 32'h0, rd);
      check("unmapped read", rd, 32'h00000000);
   endtask
   task automatic test_masks();
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, lpt_pkg::REG_OFS[i], 32'hffffffff, rd);
         bus(1'b0, lpt_pkg::REG_OFS[i], 32'h0, rd);
         check("field mask", rd, lpt_pkg::REG_MASK[i]);
      end
      bus(1'b1, lpt_pkg::OFS_CTRL, 32'hfffffffd, rd);
      bus(1'b0, lpt_pkg::OFS_CTRL, 32'h0, rd);
      check("control mask", rd, lpt_pkg::REG_MASK[lpt_pkg::I_CTRL] & 32'hfffffffd);
   endtask
   // A 64 pixel by 10 line frame, both syncs active low, display from pixel 7.
   task automatic test_tft();
      line_pol = 1'b0;
      frame_pol = 1'b0;
      run_timing({32'h00010001, 32'h3, 32'h4, 32'h9, 32'h00030000, 32'h2, 32'h3, 32'h7},
                 32'h00000003, 1500);
      check("tft sync to pixels", 32'(sync_to_pixels), 32'h6);
      check("tft frame to lines", 32'(lines_to_pixels), 32'h3);
   endtask
   // Passive panel, half pixel rate, syncs active high.
   task automatic test_passive();
      line_pol = 1'b1;
      frame_pol = 1'b1;
      run_timing({32'h00820000, 32'h0, 32'h4, 32'h9, 32'h00810002, 32'h0, 32'h3, 32'h7},
                 32'h00000012, 3000);
      check("passive sync to pixels", 32'(sync_to_pixels), 32'h26);
      check("passive frame to lines", 32'(lines_to_pixels), 32'h1);
      bus(1'b1, lpt_pkg::OFS_CTRL, 32'h00000000, rd);
      repeat (4) @(posedge core_clk_in);
   endtask
   initial begin
      repeat (5) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      test_reset_values();
      test_masks();
      test_tft();
      test_passive();
      tally_and_finish();
   end
endmodule // lpt_timing_gen_bench
